// file: rtl/clock_meter_cfg.svh
`ifndef CLOCK_METER_CFG_SVH
`define CLOCK_METER_CFG_SVH
`define EDGE_METER_OFFSET 8'h1B
`define LOCK_STATUS_OFFSET 8'h1C
`define PIN_ZERO_SETUP_OFFSET 8'h1D
`define EDGE_METER_RESET 8'h00
`define PIN_ZERO_SETUP_RESET 4'h0
`define LOCK_BIT 0
`define AUDIO_LOCK_BIT 3
`define TWO_LANE_BIT 4
`define PIN_ENABLE_BIT 0
`define PIN_DIRECTION_BIT 1
`define PIN_FAR_CONTROL_BIT 2
`define PIN_LOCAL_LEVEL_BIT 3
`define REVISION_LSB 4
`define EDGE_COUNT_MAX 8'hFF
`endif

// file: rtl/clock_meter_pkg.sv
package clock_meter_pkg;
    // pad mode from {direction, enable}
    typedef enum logic [1:0] {
        PAD_FUNCTIONAL = 2'b00,
        PAD_GPIO_OUT = 2'b01,
        PAD_TRISTATE = 2'b10,
        PAD_GPIO_IN = 2'b11
    } pad_mode_type;
    typedef enum logic [0:0] {
        METER_IDLE = 1'b0,
        METER_RUN = 1'b1
    } meter_state_type;
endpackage

// file: rtl/pin_ctl_if.sv
`timescale 1ns/1ns
interface pin_ctl_if;
    logic [3:0] setup;
    logic far_level;
    logic func_level;
    logic level;
    logic oe_n;
    modport ctl(output setup, output far_level, output func_level, input level, input oe_n);
    modport pad(input setup, input far_level, input func_level, output level, output oe_n);
endinterface

// file: rtl/pin_zero_pad.sv
`timescale 1ns/1ns
`include "clock_meter_cfg.svh"
module pin_zero_pad (
    pin_ctl_if.pad pin
);
    clock_meter_pkg::pad_mode_type mode;
    // mode decode and drive selection
    always_comb begin
        mode = clock_meter_pkg::pad_mode_type'({pin.setup[`PIN_DIRECTION_BIT],
                                                pin.setup[`PIN_ENABLE_BIT]}); // [RULE12]
        pin.level = 1'b0;
        pin.oe_n = 1'b1;
        if (pin.setup[`PIN_FAR_CONTROL_BIT]) begin
            pin.level = pin.far_level; // [RULE11]
            pin.oe_n = 1'b0;
        end else begin
            unique case (mode)
                clock_meter_pkg::PAD_FUNCTIONAL: begin
                    pin.level = pin.func_level;
                    pin.oe_n = 1'b0;
                end
                clock_meter_pkg::PAD_GPIO_OUT: begin
                    pin.level = pin.setup[`PIN_LOCAL_LEVEL_BIT]; // [RULE10]
                    pin.oe_n = 1'b0;
                end
                clock_meter_pkg::PAD_TRISTATE: begin
                    pin.oe_n = 1'b1;
                end
                clock_meter_pkg::PAD_GPIO_IN: begin
                    pin.oe_n = 1'b1;
                end
            endcase
        end
    end
endmodule // pin_zero_pad

// file: rtl/clock_meter_status_pin_zero_regs.sv
`timescale 1ns/1ns
`include "clock_meter_cfg.svh"
// Functional notes
// RULE1: a counter write starts counting pixel edges for value oscillator periods
// RULE2: counter read returns edges seen in the latest enabled interval
// RULE3: edge count saturates at its top value instead of wrapping
// RULE4: software may use the count as a rough clock estimate
// RULE5: status bit 4 shows dual-link mode
// RULE6: status bit 3 shows audio serial clock lock
// RULE7: status bit 0 shows recovered clock lock
// RULE8: in dual-link mode lock needs both channels locked
// RULE9: second port select steers pin setup to second port pin
// RULE10: local level drives pin in general output mode, far control off
// RULE11: far control bit makes pin an output with remote value
// RULE12: direction and enable decode: 00 func, 10 tristate, 01 out, 11 in
// RULE13: a new counter write restarts measurement and clears count
// RULE14: further pins use the same field layout
module clock_meter_status_pin_zero_regs #(
    parameter logic [3:0] SILICON_REVISION_CODE = 4'h5 // arbitrary value
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic pixel_clk_level,
    input wire logic lane0_locked,
    input wire logic lane1_locked,
    input wire logic two_lane_receive_flag,
    input wire logic audio_pll_locked,
    input wire logic second_port_select,
    input wire logic far_level_port0,
    input wire logic far_level_port1,
    input wire logic func_level_port0,
    input wire logic func_level_port1,
    output logic pin_zero_out,
    output logic pin_zero_oe_n,
    input wire logic pin_zero_in,
    output logic second_port_pin_zero_out,
    output logic second_port_pin_zero_oe_n,
    input wire logic second_port_pin_zero_in
);
    // meter state: running flag, remaining periods and edge tally
    clock_meter_pkg::meter_state_type state_q;
    clock_meter_pkg::meter_state_type state_d;
    logic [7:0] interval_q;
    logic [7:0] interval_d;
    logic [7:0] count_q;
    logic [7:0] count_d;
    // previous pixel level for the edge detector
    logic pix_prev_q;
    logic pix_prev_d;
    // one four-bit setup copy per port, selected by the port select level
    logic [3:0] setup0_q;
    logic [3:0] setup0_d;
    logic [3:0] setup1_q;
    logic [3:0] setup1_d;
    // registered read data, held between reads
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic pix_edge;
    logic link_locked;
    logic [3:0] setup_sel;
    logic pad_in;
    pin_ctl_if pin ();

    // address match shared by the write decoders and the read mux;
    // full eight-bit compare, so aliases of the three offsets are not hit
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] offs);
        hit = (addr == offs);
    endfunction

    // rising edge of the pixel clock sampled on the oscillator clock
    assign pix_edge = pixel_clk_level & ~pix_prev_q;
    // dual-link lock needs both lanes; single-link uses lane 0 only
    assign link_locked = two_lane_receive_flag ? (lane0_locked & lane1_locked)
                                               : lane0_locked; // [RULE8]
    assign setup_sel = second_port_select ? setup1_q : setup0_q; // [RULE9]
    assign pad_in = second_port_select ? second_port_pin_zero_in : pin_zero_in;

    // meter: interval countdown and saturating edge count
    // the pixel clock is only sampled here, so at most one rising edge can
    // be seen every two oscillator periods; a 255-period window tops out
    // near 127 edges, and the saturation guard only matters if the window
    // or the sampling is ever widened
    // a write of zero leaves the meter idle with a cleared count, which
    // gives software a way to abandon a measurement without starting one
    // the count is not frozen by a read, so a read mid-interval is partial
    always_comb begin
        state_d = state_q;
        interval_d = interval_q;
        count_d = count_q;
        pix_prev_d = pixel_clk_level;
        if (reg_wr && hit(reg_addr, `EDGE_METER_OFFSET)) begin
            interval_d = reg_wdata; // [RULE1]
            count_d = `EDGE_METER_RESET; // [RULE13]
            state_d = (reg_wdata == 8'h00) ? clock_meter_pkg::METER_IDLE
                                           : clock_meter_pkg::METER_RUN;
        end else begin
            unique case (state_q)
                clock_meter_pkg::METER_IDLE: begin
                end
                clock_meter_pkg::METER_RUN: begin
                    // count rising pixel edges; the interval drops one oscillator period per cycle
                    if (pix_edge && count_q != `EDGE_COUNT_MAX) begin
                        count_d = count_q + 8'h01; // [RULE3]
                    end
                    interval_d = interval_q - 8'h01;
                    if (interval_q == 8'h01) begin
                        state_d = clock_meter_pkg::METER_IDLE; // [RULE1]
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= clock_meter_pkg::METER_IDLE;
            interval_q <= 8'h00;
            count_q <= `EDGE_METER_RESET;
            pix_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            interval_q <= interval_d;
            count_q <= count_d;
            pix_prev_q <= pix_prev_d;
        end
    end

    // pin setup writes go to the selected port's copy
    // bits 7:4 of the write are dropped: that nibble reads the revision code
    // the select is a level, so it must settle before the write strobe
    always_comb begin
        setup0_d = setup0_q;
        setup1_d = setup1_q;
        if (reg_wr && hit(reg_addr, `PIN_ZERO_SETUP_OFFSET)) begin
            if (second_port_select) begin
                setup1_d = reg_wdata[3:0]; // [RULE9]
            end else begin
                setup0_d = reg_wdata[3:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            setup0_q <= `PIN_ZERO_SETUP_RESET;
            setup1_q <= `PIN_ZERO_SETUP_RESET;
        end else begin
            setup0_q <= setup0_d;
            setup1_q <= setup1_d;
        end
    end

    // read mux; count reads live, so a read mid-interval shows partial count
    // unmapped offsets read zero; the status bits are sampled at the read
    // edge, so a lock change between strobe and use is not reflected
    // the revision nibble is a parameter with an arbitrary default value
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            rdata_d = 8'h00;
            if (hit(reg_addr, `EDGE_METER_OFFSET)) begin
                rdata_d = count_q; // [RULE2]
            end else if (hit(reg_addr, `LOCK_STATUS_OFFSET)) begin
                rdata_d[`TWO_LANE_BIT] = two_lane_receive_flag; // [RULE5]
                rdata_d[`AUDIO_LOCK_BIT] = audio_pll_locked; // [RULE6]
                rdata_d[`LOCK_BIT] = link_locked; // [RULE7]
            end else if (hit(reg_addr, `PIN_ZERO_SETUP_OFFSET)) begin
                rdata_d = {SILICON_REVISION_CODE, setup_sel}; // [RULE14]
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // one pad decoder per port keeps the unselected pin's setup live
    // trade-off: two decoders instead of one, but flipping the select never
    // glitches the pin that software is not currently addressing
    // the pad inputs are taken but not yet read back through any register
    assign pin.setup = setup0_q;
    assign pin.far_level = far_level_port0;
    assign pin.func_level = func_level_port0;
    pin_zero_pad pad0 (
        .pin(pin)
    );
    pin_ctl_if pin1 ();
    assign pin1.setup = setup1_q;
    assign pin1.far_level = far_level_port1;
    assign pin1.func_level = func_level_port1;
    pin_zero_pad pad1 (
        .pin(pin1)
    );
    assign pin_zero_out = pin.level;
    assign pin_zero_oe_n = pin.oe_n;
    assign second_port_pin_zero_out = pin1.level;
    assign second_port_pin_zero_oe_n = pin1.oe_n;
endmodule // clock_meter_status_pin_zero_regs

// file: bench/clock_meter_status_pin_zero_regs_assertions.sv
`timescale 1ns/1ns
module clock_meter_status_pin_zero_regs_assertions (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic lane0_locked,
    input wire logic lane1_locked,
    input wire logic two_lane_receive_flag,
    input wire logic audio_pll_locked,
    input wire logic second_port_select,
    input wire logic far_level_port0,
    input wire logic far_level_port1,
    input wire logic func_level_port0,
    input wire logic pin_zero_out,
    input wire logic pin_zero_oe_n,
    input wire logic second_port_pin_zero_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // setup write aimed at the first port's copy
    sequence first_wr; reg_wr && reg_addr == 8'h1D && !second_port_select; endsequence
    a_unmapped_read_zero: assert property (reg_rd && !(reg_addr inside {8'h1B, 8'h1C, 8'h1D})
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_status_read_bits: assert property (reg_rd && reg_addr == 8'h1C |=> reg_rdata == {3'h0,
        $past(two_lane_receive_flag), $past(audio_pll_locked), 2'h0,
        $past(lane0_locked) & ($past(lane1_locked) | !$past(two_lane_receive_flag))})
        else $error("status read wrong");
    a_read_data_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
    a_far_drive_pin: assert property (first_wr ##0 reg_wdata[2] |=>
        !pin_zero_oe_n && pin_zero_out == far_level_port0) else $error("far drive wrong");
    a_local_level_pin: assert property (first_wr ##0 reg_wdata[2:0] == 3'h1 |=>
        !pin_zero_oe_n && pin_zero_out == $past(reg_wdata[3])) else $error("local level wrong");
    a_func_mode_pin: assert property (first_wr ##0 reg_wdata[2:0] == 3'h0 |=>
        !pin_zero_oe_n && pin_zero_out == func_level_port0) else $error("func mode wrong");
    a_tristate_pin_off: assert property (first_wr ##0 reg_wdata[2:1] == 2'h1 |=>
        pin_zero_oe_n && !pin_zero_out) else $error("pin not released");
    a_second_port_far: assert property (reg_wr && reg_addr == 8'h1D && second_port_select
        && reg_wdata[2] |=> second_port_pin_zero_out == far_level_port1) else $error("port steer");
endmodule // clock_meter_status_pin_zero_regs_assertions
bind clock_meter_status_pin_zero_regs clock_meter_status_pin_zero_regs_assertions checker_i (
    .core_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .lane0_locked,
    .lane1_locked, .two_lane_receive_flag, .audio_pll_locked, .second_port_select,
    .far_level_port0, .far_level_port1, .func_level_port0, .pin_zero_out, .pin_zero_oe_n,
    .second_port_pin_zero_out);

// file: bench/far_serializer_model.sv
`timescale 1ns/1ns
module far_serializer_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic slow,
    output logic pixel_clk_level,
    output logic far_level_port0,
    output logic far_level_port1
);
    logic [1:0] phase_q;
    // free running; far values change every cycle so a stale copy cannot pass
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n) phase_q <= 2'h0;
        else phase_q <= phase_q + 2'h1;
    assign pixel_clk_level = slow ? phase_q[1] : phase_q[0];
    assign far_level_port0 = phase_q[0];
    assign far_level_port1 = ~phase_q[0];
endmodule // far_serializer_model

// file: bench/testbench.sv
`timescale 1ns/1ns
module testbench;
    typedef struct packed {logic sel; logic [3:0] cfg; logic [1:0] src; logic oe_n;} row_type;
    // src: 0 low, 1 high (func levels tied high), 3 follows far serializer
    localparam row_type ROWS [8] = '{'{1'b0, 4'h0, 2'h1, 1'b0}, '{1'b0, 4'h1, 2'h0, 1'b0},
        '{1'b0, 4'h9, 2'h1, 1'b0}, '{1'b0, 4'hA, 2'h0, 1'b1}, '{1'b0, 4'hB, 2'h0, 1'b1},
        '{1'b0, 4'hC, 2'h3, 1'b0}, '{1'b1, 4'h4, 2'h3, 1'b0}, '{1'b1, 4'h1, 2'h0, 1'b0}};
    localparam logic [3:0] REV = 4'hA; // arbitrary revision code
    logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
    logic second_port_select = 1'b0, far_level_port0, far_level_port1, pixel_clk_level;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, got;
    logic [3:0] lk = 4'h0; // two-lane, audio, lane1, lane0
    logic o0, e0, o1, e1, want;
    int failures = 0, comparisons = 0;
    clock_meter_status_pin_zero_regs #(.SILICON_REVISION_CODE(REV)) clock_meter_status_pin_zero_regs_i (
        .core_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .pixel_clk_level,
        .lane0_locked(lk[0]), .lane1_locked(lk[1]), .two_lane_receive_flag(lk[3]),
        .audio_pll_locked(lk[2]), .second_port_select, .far_level_port0, .far_level_port1,
        .func_level_port0(1'b1), .func_level_port1(1'b1), .pin_zero_out(o0), .pin_zero_oe_n(e0),
        .pin_zero_in(1'b0), .second_port_pin_zero_out(o1), .second_port_pin_zero_oe_n(e1),
        .second_port_pin_zero_in(1'b0));
    far_serializer_model far_serializer_model_i (.core_clk, .rst_n, .slow, .pixel_clk_level,
        .far_level_port0, .far_level_port1);
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // strobes drop and one idle cycle follows, so tasks chain safely
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk) reg_wr = 1'b0;
        @(negedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk) reg_rd = 1'b0;
        got = reg_rdata;
        @(negedge core_clk);
    endtask
    // windows that are multiples of four make the count independent of pixel phase
    task automatic meter(input logic s, input logic [7:0] n, input logic [7:0] e);
        slow = s;
        wr(8'h1B, n);
        repeat (n + 4) @(negedge core_clk);
        rd(8'h1B);
        check(got, e);
    endtask
    task automatic test_done();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        test_done();
    end
    initial begin
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        rd(8'h1B);
        check(got, 8'h00);
        rd(8'h1D);
        check(got, {REV, 4'h0});
        wr(8'h1C, 8'hFF);
        rd(8'h1C);
        check(got, 8'h00);
        wr(8'h1A, 8'hFF);
        rd(8'h1A);
        check(got, 8'h00);
        $display("reset and access test done");
        foreach (ROWS[i]) begin
            second_port_select = ROWS[i].sel;
            wr(8'h1D, {4'h0, ROWS[i].cfg});
            want = ROWS[i].src == 2'h3 ? (ROWS[i].sel ? far_level_port1 : far_level_port0)
                : ROWS[i].src[0];
            check(ROWS[i].sel ? {e1, o1} : {e0, o0}, {ROWS[i].oe_n, want});
            rd(8'h1D);
            check(got, {REV, ROWS[i].cfg});
        end
        $display("pin table test done");
        for (int i = 0; i < 16; i++) begin
            lk = 4'(i);
            rd(8'h1C);
            check(got, {3'h0, lk[3], lk[2], 2'h0, lk[0] & (lk[1] | !lk[3])});
        end
        $display("status test done");
        meter(1'b0, 8'h40, 8'h20);
        meter(1'b1, 8'hFC, 8'h3F);
        meter(1'b0, 8'h00, 8'h00);
        wr(8'h1B, 8'hC0);
        meter(1'b0, 8'h10, 8'h08);
        $display("meter test done");
        // mid-run reset with setup and a measurement live
        second_port_select = 1'b0;
        wr(8'h1D, 8'h09);
        wr(8'h1B, 8'h40);
        repeat (10) @(negedge core_clk);
        rst_n = 1'b0;
        @(negedge core_clk);
        check({e0, o0}, 2'b01);
        check(reg_rdata, 8'h00);
        rst_n = 1'b1;
        rd(8'h1B);
        check(got, 8'h00);
        rd(8'h1D);
        check(got, {REV, 4'h0});
        $display("mid-run reset test done");
        test_done();
    end
endmodule // testbench
